/* rtl/rps_pkg.sv */
// Constants and types for the RAM pointer and indirect-select register bank.
// Assumes a classic Wishbone slave with 32-bit data, registers in the low byte.
// How it works
// [R1] Bit 7 of the pointer high register says whether the next RAM data access is a read (1) or a write (0).
// [R2] With bit 6 of the pointer high register set the pointer steps after each data access, else it holds.
// [R3] Software writes zero to bits 5 to 3 of the pointer high register, which have no function.
// [R4] Bits 2 to 0 of the pointer high register give RAM address bits 10 to 8.
// [R5] All eight bits of the pointer low register give RAM address bits 7 to 0.
// [R6] The three-bit selector picks which indirect register answers at register address 07.
// [R7] Selector 0 to 4 pick tentative ID, node ID, setup one, next ID, setup two; 5 to 7 pick nothing.
// [R8] The two low selector bits are the same flops as config bits 1 and 0, so either write updates both.
// [R9] Any write to the configuration register clears the top selector bit.
// [R10] The two pointer bytes form one 11-bit pointer and stepping carries from the low byte upward.
// [R11] Software writes zero to bits 7 to 3 of the selector register.
package rps_pkg;
    // Byte addresses on the bus
    localparam logic [4:0] ADR_PTR_HIGH = 5'h08;
    localparam logic [4:0] ADR_PTR_LOW = 5'h0C;
    localparam logic [4:0] ADR_SUB_SEL = 5'h14;
    localparam logic [4:0] ADR_CONFIG = 5'h18;
    localparam logic [4:0] ADR_INDIRECT = 5'h1C;
    // Field positions
    localparam int HIGH_DIR_BIT = 7;
    localparam int HIGH_STEP_BIT = 6;
    localparam int HIGH_UPPER_MSB = 2;
    localparam int SUB_TOP_BIT = 2;
    localparam int CFG_SUB_MSB = 1;
    // Widths and reset values
    localparam int PTR_W = 11;
    localparam logic [10:0] PTR_RST = 11'h000;
    localparam logic [5:0] CFG_UP_RST = 6'h00;
    localparam logic [2:0] SUB_RST = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        SEL_TENT_ID = 3'b000,
        SEL_NODE_ID = 3'b001,
        SEL_SETUP1 = 3'b010,
        SEL_NEXT_ID = 3'b011,
        SEL_SETUP2 = 3'b100
    } rps_sel_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } rps_bus_t;
endpackage : rps_pkg

/* rtl/rps_regs.sv */
// Pointer, selector and configuration registers behind a Wishbone slave.
// Assumes the data-port logic pulses dataAccess once per RAM byte moved,
// and the indirect registers live outside, reached through indSel.
`timescale 1ns/100ps
`default_nettype none
module rps_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [4:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // RAM data port side
    input wire logic dataAccess,
    output logic [10:0] ramAddr,
    output logic readDirection,
    output logic autoStep,
    // Indirect register side
    input wire logic [7:0] indRdData,
    output logic [2:0] indSel,
    output logic indValid,
    output logic indWrStrobe,
    output logic [7:0] indWrData,
    // Configuration view
    output logic [7:0] cfgValue
);

    function automatic logic isHit(input logic [4:0] adr, input logic [4:0] off);
        isHit = (adr[4:2] == off[4:2]);
    endfunction : isHit

    function automatic logic selUsed(input logic [2:0] s);
        selUsed = (s <= rps_pkg::SEL_SETUP2);
    endfunction : selUsed

    rps_pkg::rps_bus_t busR;
    logic [10:0] ptrR;
    logic dirR;
    logic stepR;
    logic subTopR;
    logic [1:0] subLowR;
    logic [5:0] cfgUpR;
    logic [7:0] rdByte;
    logic [31:0] datR;
    logic indStrobeR;
    logic [7:0] indDataR;
    logic wrEn;
    logic wrHigh;
    logic wrLow;
    logic wrSub;
    logic wrCfg;
    logic wrInd;
    logic stepNow;

    // Writes land at the edge where the master sees ack
    assign wrEn = (busR == rps_pkg::BUS_ACK) && wbCyc && wbStb && wbWe && wbSel[0];
    assign wrHigh = wrEn && isHit(wbAdr, rps_pkg::ADR_PTR_HIGH);
    assign wrLow = wrEn && isHit(wbAdr, rps_pkg::ADR_PTR_LOW);
    assign wrSub = wrEn && isHit(wbAdr, rps_pkg::ADR_SUB_SEL);
    assign wrCfg = wrEn && isHit(wbAdr, rps_pkg::ADR_CONFIG);
    assign wrInd = wrEn && isHit(wbAdr, rps_pkg::ADR_INDIRECT);
    // Host pointer write beats a step in the same cycle
    assign stepNow = dataAccess && stepR && !wrHigh && !wrLow; // see [R2]

    // Bus handshake: one wait cycle, ack for one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busR <= rps_pkg::BUS_IDLE;
        end else begin
            case (busR)
                rps_pkg::BUS_IDLE: begin
                    if (wbCyc && wbStb) begin
                        busR <= rps_pkg::BUS_ACK;
                    end
                end
                rps_pkg::BUS_ACK: begin
                    busR <= rps_pkg::BUS_IDLE;
                end
                default: begin
                    busR <= rps_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    assign wbAck = (busR == rps_pkg::BUS_ACK);

    // Read mux; reserved bits and unmapped words read zero
    always_comb begin
        rdByte = rps_pkg::BYTE_ZERO;
        if (isHit(wbAdr, rps_pkg::ADR_PTR_HIGH)) begin
            rdByte = {dirR, stepR, 3'h0, ptrR[10:8]};
        end else if (isHit(wbAdr, rps_pkg::ADR_PTR_LOW)) begin
            rdByte = ptrR[7:0];
        end else if (isHit(wbAdr, rps_pkg::ADR_SUB_SEL)) begin
            rdByte = {5'h00, subTopR, subLowR};
        end else if (isHit(wbAdr, rps_pkg::ADR_CONFIG)) begin
            rdByte = {cfgUpR, subLowR};
        end else if (isHit(wbAdr, rps_pkg::ADR_INDIRECT)) begin
            rdByte = indValid ? indRdData : rps_pkg::BYTE_ZERO; // see [R7]
        end
    end

    // Read data captured as the request is taken, held through ack
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            datR <= 32'h0000_0000;
        end else if (busR == rps_pkg::BUS_IDLE && wbCyc && wbStb) begin
            datR <= {24'h00_0000, rdByte};
        end
    end

    assign wbDatOut = datR;

    // Direction and step controls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dirR <= 1'b0;
            stepR <= 1'b0;
        end else if (wrHigh) begin
            dirR <= wbDatIn[rps_pkg::HIGH_DIR_BIT]; // see [R1]
            stepR <= wbDatIn[rps_pkg::HIGH_STEP_BIT]; // see [R2]
        end
    end

    // One 11-bit pointer; bits 5 to 3 of the high byte are dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptrR <= rps_pkg::PTR_RST;
        end else if (wrHigh) begin
            ptrR[10:8] <= wbDatIn[rps_pkg::HIGH_UPPER_MSB:0]; // see [R4]
        end else if (wrLow) begin
            ptrR[7:0] <= wbDatIn[7:0]; // see [R5]
        end else if (stepNow) begin
            ptrR <= ptrR + 11'h001; // see [R10]
        end
    end

    // Low selector bits shared by both registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            subLowR <= rps_pkg::SUB_RST[1:0];
        end else if (wrSub || wrCfg) begin
            subLowR <= wbDatIn[rps_pkg::CFG_SUB_MSB:0]; // see [R8]
        end
    end

    // Top selector bit; config write clears it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            subTopR <= rps_pkg::SUB_RST[2];
        end else if (wrCfg) begin
            subTopR <= 1'b0; // see [R9]
        end else if (wrSub) begin
            subTopR <= wbDatIn[rps_pkg::SUB_TOP_BIT];
        end
    end

    // Rest of the configuration register, kept for the outside
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfgUpR <= rps_pkg::CFG_UP_RST;
        end else if (wrCfg) begin
            cfgUpR <= wbDatIn[7:2];
        end
    end

    // Indirect write strobe; reserved selections go nowhere
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            indStrobeR <= 1'b0;
            indDataR <= rps_pkg::BYTE_ZERO;
        end else begin
            indStrobeR <= wrInd && indValid; // see [R6] [R7]
            if (wrInd) begin
                indDataR <= wbDatIn[7:0];
            end
        end
    end

    assign ramAddr = ptrR;
    assign readDirection = dirR;
    assign autoStep = stepR;
    assign indSel = {subTopR, subLowR}; // see [R6]
    assign indValid = selUsed(indSel); // see [R7]
    assign indWrStrobe = indStrobeR;
    assign indWrData = indDataR;
    assign cfgValue = {cfgUpR, subLowR};

    // Checks
    sequence wrHighSeq;
        wrHigh;
    endsequence

    sequence wrCfgSeq;
        wrCfg && !wrSub;
    endsequence

    sequence wrIndSeq;
        wrInd;
    endsequence

    sequence rdTakenSeq;
        busR == rps_pkg::BUS_IDLE && wbCyc && wbStb && !wbWe;
    endsequence

    sequence takenSeq;
        busR == rps_pkg::BUS_IDLE && wbCyc && wbStb;
    endsequence

    dir_flag_a: assert property (@(posedge clk) disable iff (!resetn) // see [R1]
        wrHighSeq |=> readDirection == $past(wbDatIn[7]))
        else $error("Direction flag not loaded from write");

    step_add_a: assert property (@(posedge clk) disable iff (!resetn) // see [R2]
        (dataAccess && autoStep && !wrHigh && !wrLow)
        |=> ramAddr == $past(ramAddr) + 11'h001)
        else $error("Pointer did not step after access");

    ptr_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see [R2]
        (!(dataAccess && autoStep) && !wrHigh && !wrLow) |=> $stable(ramAddr))
        else $error("Pointer moved without cause");

    upper_bits_a: assert property (@(posedge clk) disable iff (!resetn) // see [R4]
        wrHighSeq |=> ramAddr[10:8] == $past(wbDatIn[2:0]) && $stable(ramAddr[7:0]))
        else $error("Upper pointer bits wrong after write");

    lower_bits_a: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        wrLow |=> ramAddr[7:0] == $past(wbDatIn[7:0]) && $stable(ramAddr[10:8]))
        else $error("Lower pointer bits wrong after write");

    carry_wrap_a: assert property (@(posedge clk) disable iff (!resetn) // see [R10]
        (stepNow && ramAddr[7:0] == 8'hFF) |=> ramAddr[7:0] == 8'h00
        && ramAddr[10:8] == $past(ramAddr[10:8]) + 3'h1)
        else $error("Step did not carry into upper bits");

    ind_strobe_a: assert property (@(posedge clk) disable iff (!resetn) // see [R6]
        (wrIndSeq and (indSel <= 3'h4)) |=> indWrStrobe && indWrData == $past(wbDatIn[7:0])
        && indSel == $past(indSel) ##1 !indWrStrobe)
        else $error("Indirect write not delivered once");

    reserved_sel_a: assert property (@(posedge clk) disable iff (!resetn) // see [R7]
        (indSel > 3'h4) |-> !indValid)
        else $error("Reserved selector marked valid");

    reserved_wr_a: assert property (@(posedge clk) disable iff (!resetn) // see [R7]
        (wrIndSeq and (indSel > 3'h4)) |=> !indWrStrobe)
        else $error("Reserved selector reached a register");

    shared_bits_a: assert property (@(posedge clk) disable iff (!resetn) // see [R8]
        (wrSub || wrCfg) |=> indSel[1:0] == $past(wbDatIn[1:0]) && cfgValue[1:0] == indSel[1:0])
        else $error("Shared selector bits disagree");

    top_clear_a: assert property (@(posedge clk) disable iff (!resetn) // see [R9]
        wrCfgSeq |=> !indSel[2] && cfgValue[7:2] == $past(wbDatIn[7:2]))
        else $error("Config write left top selector set");

    // Ack is one pulse a cycle after the request is taken; read data reflects the state at the edge the request is taken
    ack_once_a: assert property (@(posedge clk) disable iff (!resetn)
        takenSeq |-> !wbAck ##1 wbAck ##1 !wbAck)
        else $error("Ack not a single pulse after request");

    data_upper_a: assert property (@(posedge clk) disable iff (!resetn)
        wbAck |-> wbDatOut[31:8] == 24'h00_0000)
        else $error("Read data upper bits not zero");

    read_high_a: assert property (@(posedge clk) disable iff (!resetn) // see [R1] [R4]
        (rdTakenSeq and isHit(wbAdr, rps_pkg::ADR_PTR_HIGH))
        |=> wbDatOut[7:0] == {$past(readDirection), $past(autoStep), 3'h0, $past(ramAddr[10:8])})
        else $error("Pointer high read back wrong");

    read_low_a: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        (rdTakenSeq and isHit(wbAdr, rps_pkg::ADR_PTR_LOW)) |=> wbDatOut[7:0] == $past(ramAddr[7:0]))
        else $error("Pointer low read back wrong");

    read_sel_a: assert property (@(posedge clk) disable iff (!resetn) // see [R6]
        (rdTakenSeq and isHit(wbAdr, rps_pkg::ADR_INDIRECT) and (indSel <= 3'h4))
        |=> wbDatOut[7:0] == $past(indRdData))
        else $error("Indirect read not from selected register");

    read_rsvd_a: assert property (@(posedge clk) disable iff (!resetn) // see [R7]
        (rdTakenSeq and isHit(wbAdr, rps_pkg::ADR_INDIRECT) and (indSel > 3'h4))
        |=> wbDatOut[7:0] == 8'h00)
        else $error("Reserved selector read not zero");

    ctrl_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see [R1] [R2]
        !wrHigh |=> $stable(readDirection) && $stable(autoStep))
        else $error("Direction or step flag moved without write");

    sel_load_a: assert property (@(posedge clk) disable iff (!resetn) // see [R6]
        (wrSub && !wrCfg) |=> indSel == $past(wbDatIn[2:0]))
        else $error("Selector not loaded from write");

    sel_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see [R8]
        (!wrSub && !wrCfg) |=> $stable(indSel))
        else $error("Selector moved without write");

endmodule : rps_regs
`default_nettype wire

/* sim/rps_ind_model.sv */
// Behavioural indirect registers seen through the selector.
// Assumes one write strobe per access, on the bank's clock.
`timescale 1ns/100ps
`default_nettype none
module rps_ind_model (
    // Clock
    input wire logic clk,
    // Indirect side
    input wire logic [2:0] indSel,
    input wire logic indWrStrobe,
    input wire logic [7:0] indWrData,
    output logic [7:0] indRdData
);
    logic [7:0] mem [0:4];
    logic [7:0] noise = 8'h5A;
    initial for (int i = 0; i < 5; i++) mem[i] = 8'h00;
    // Reserved codes show churn, so a stale zero cannot pass by luck
    always @(posedge clk) begin
        noise <= ~noise + 8'h01;
        if (indWrStrobe && indSel < 3'h5) mem[indSel] <= indWrData;
    end
    always_comb indRdData = (indSel < 3'h5) ? mem[indSel] : noise;
endmodule : rps_ind_model
`default_nettype wire

/* sim/rps_regs_tb.sv */
// Self-checking bench for the pointer and selector bank.
// Assumes the bank answers each Wishbone request with a one-cycle ack.
`timescale 1ns/100ps
`default_nettype none
module rps_regs_tb;
    logic clk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, dataAccess = 0;
    logic [4:0] wbAdr = 5'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0000_0000, wbDatOut, rd;
    logic wbAck, readDirection, autoStep, indValid, indWrStrobe;
    logic [10:0] ramAddr;
    logic [7:0] indRdData, indWrData, cfgValue;
    logic [2:0] indSel;
    int errorCnt = 0, checks = 0, ptr = 0, dir = 0, step = 0, sel = 0, cfgU = 0, v, s;

    rps_regs i_dut (.clk(clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .dataAccess(dataAccess),
        .ramAddr(ramAddr), .readDirection(readDirection), .autoStep(autoStep), .indRdData(indRdData),
        .indSel(indSel), .indValid(indValid), .indWrStrobe(indWrStrobe), .indWrData(indWrData),
        .cfgValue(cfgValue));
    rps_ind_model i_ind (.clk(clk), .indSel(indSel), .indWrStrobe(indWrStrobe), .indWrData(indWrData),
        .indRdData(indRdData));

    initial forever #4 clk = ~clk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [4:0] a, input int d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'h1;
        wbDatIn <= 32'(d & 255);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1);
        chk("ackWait", 2, n);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(negedge clk);
    endtask : bus

    task automatic st;
        chk("ramAddr", ptr, ramAddr);
        chk("readDirection", dir, readDirection);
        chk("autoStep", step, autoStep);
        chk("indSel", sel, indSel);
        chk("indValid", sel < 5, indValid);
        chk("cfgValue", cfgU * 4 + sel % 4, cfgValue);
    endtask : st

    task automatic pulse;
        @(posedge clk);
        dataAccess <= 1'b1;
        @(posedge clk);
        dataAccess <= 1'b0;
        @(negedge clk);
    endtask : pulse

    task automatic summarize;
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial begin
        #100us;
        errorCnt++;
        summarize;
    end

    initial begin
        v = $urandom(32'hec7afde1);
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        bus(0, rps_pkg::ADR_PTR_HIGH, 0, rd);
        chk("ptrHigh", 0, rd);
        st;
        $display("test reset done");
        repeat (4) begin
            v = $urandom;
            bus(1, rps_pkg::ADR_PTR_HIGH, v & 'hC7, rd);
            bus(1, rps_pkg::ADR_PTR_LOW, v >> 8, rd);
            dir = v >> 7 & 1;
            step = v >> 6 & 1;
            ptr = (v & 7) * 256 + (v >> 8 & 255);
            st;
            bus(0, rps_pkg::ADR_PTR_HIGH, 0, rd);
            chk("ptrHigh", v & 'hC7, rd);
            bus(0, rps_pkg::ADR_PTR_LOW, 0, rd);
            chk("ptrLow", ptr % 256, rd);
        end
        $display("test pointer writes done");
        // Carry into the upper bits, then wrap at the top of the buffer
        for (v = 3; v < 8; v += 4) begin
            bus(1, rps_pkg::ADR_PTR_HIGH, 'h40 + v, rd);
            bus(1, rps_pkg::ADR_PTR_LOW, 'hFF, rd);
            dir = 0;
            step = 1;
            pulse;
            ptr = (v * 256 + 256) % 2048;
            st;
        end
        bus(1, rps_pkg::ADR_PTR_HIGH, 'h80, rd);
        dir = 1;
        step = 0;
        pulse;
        st;
        $display("test auto step done");
        for (s = 0; s < 8; s++) begin
            bus(1, rps_pkg::ADR_SUB_SEL, s, rd);
            sel = s;
            v = $urandom % 256;
            bus(1, rps_pkg::ADR_INDIRECT, v, rd);
            chk("indWrStrobe", s < 5, indWrStrobe);
            chk("indWrData", v, indWrData);
            bus(0, rps_pkg::ADR_INDIRECT, 0, rd);
            chk("indirect", s < 5 ? v : 0, rd);
            bus(0, rps_pkg::ADR_SUB_SEL, 0, rd);
            chk("subSel", s, rd);
            st;
        end
        $display("test selector codes done");
        v = $urandom % 256;
        bus(1, rps_pkg::ADR_CONFIG, v, rd);
        cfgU = v / 4;
        sel = v % 4;
        st;
        bus(1, rps_pkg::ADR_SUB_SEL, 5, rd);
        sel = 5;
        st;
        bus(0, rps_pkg::ADR_CONFIG, 0, rd);
        chk("config", cfgU * 4 + 1, rd);
        bus(0, 5'h00, 0, rd);
        chk("unmapped", 0, rd);
        $display("test config sharing done");
        summarize;
    end
endmodule : rps_regs_tb
`default_nettype wire
